/* logic/tpoc_pkg.sv */
// Purpose: shared constants for the timing pattern output controller
// Assumes: 32-bit AXI4-Lite register access, byte address = 4 * index
// Notes: register indices are kept as printed, all registers 8 or 16 bits
package tpoc_pkg;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int unsigned TPOC_GROUPS = 4;
    localparam int unsigned TPOC_PINS = 16;
    localparam int unsigned TPOC_CHANNELS = 4;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [29:0] TPOC_IDX_MODE = 30'h05fffff0;
    localparam logic [29:0] TPOC_IDX_TRIG = 30'h05fffff1;
    localparam logic [29:0] TPOC_IDX_EN_HIGH = 30'h05fffff2;
    localparam logic [29:0] TPOC_IDX_EN_LOW = 30'h05fffff3;
    localparam logic [29:0] TPOC_IDX_STAGE_B_UP = 30'h05fffff4;
    localparam logic [29:0] TPOC_IDX_STAGE_A_UP = 30'h05fffff5;
    localparam logic [29:0] TPOC_IDX_STAGE_B_LO = 30'h05fffff6;
    localparam logic [29:0] TPOC_IDX_STAGE_A_LO = 30'h05fffff7;
    localparam logic [29:0] TPOC_IDX_PIN_FN_HIGH = 30'h05ffffcc;
    localparam logic [29:0] TPOC_IDX_PIN_FN_LOW = 30'h05ffffce;

    // ****************************************************************
    // reset values and fields
    // ****************************************************************
    localparam logic [3:0] TPOC_MODE_RESET = 4'h0;
    localparam logic [7:0] TPOC_MODE_RSVD = 8'hf0;
    localparam logic [7:0] TPOC_TRIG_RESET = 8'hff;
    localparam logic [7:0] TPOC_EN_RESET = 8'h00;
    localparam logic [3:0] TPOC_STAGE_RESET = 4'h0;
    localparam logic [15:0] TPOC_PIN_FN_RESET = 16'h0000;
    localparam logic [1:0] TPOC_PIN_FN_PATTERN = 2'h3;
    localparam logic [3:0] TPOC_NIBBLE_RSVD = 4'hf;
    localparam logic [7:0] TPOC_BYTE_RSVD = 8'hff;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0] TPOC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TPOC_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        TPOC_REG_MODE,
        TPOC_REG_TRIG,
        TPOC_REG_EN_HIGH,
        TPOC_REG_EN_LOW,
        TPOC_REG_STAGE_B_UP,
        TPOC_REG_STAGE_A_UP,
        TPOC_REG_STAGE_B_LO,
        TPOC_REG_STAGE_A_LO,
        TPOC_REG_PIN_FN_HIGH,
        TPOC_REG_PIN_FN_LOW,
        TPOC_REG_NONE
    } tpoc_reg_e;

endpackage

/* logic/tpoc_group.sv */
// Purpose: one four-bit pattern output group
// Assumes: trigger pulses are one cycle wide and already channel-selected
// Notes: in split-edge mode both matches may land in one cycle
`timescale 1ns/1ns
module tpoc_group
    import tpoc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic trig_a,
    input wire logic trig_b,
    input wire logic split_edge_mode,
    input wire logic [3:0] enable,
    input wire logic [3:0] staged,
    output logic [3:0] pattern_q
);

    logic [3:0] pattern_d;

    // ****************************************************************
    // next pattern value
    // ****************************************************************
    always_comb
    begin
        pattern_d = pattern_q;
        if (!split_edge_mode)
        begin
            // disabled bits keep their level
            if (trig_a)
            begin
                pattern_d = (pattern_q & ~enable) | (staged & enable);
            end
        end
        else
        begin
            // ones rise on match a, zeros fall on match b
            if (trig_a)
            begin
                pattern_d = pattern_d | (staged & enable);
            end
            if (trig_b)
            begin
                pattern_d = pattern_d & ~(~staged & enable);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pattern_q <= TPOC_STAGE_RESET;
        end
        else
        begin
            pattern_q <= pattern_d;
        end
    end

endmodule // tpoc_group

/* logic/tpoc_pin_mux.sv */
// Purpose: port b pin function mux
// Assumes: two function bits per pin, pin n at bits 2n+1..2n
// Notes: output is registered, so a pin lags its source by one cycle
`timescale 1ns/1ns
module tpoc_pin_mux
    import tpoc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] pin_function,
    input wire logic [15:0] pattern,
    input wire logic [15:0] general_out,
    output logic [15:0] port_b_pins
);

    // ****************************************************************
    // per-pin selection
    // ****************************************************************
    for (genvar n = 0; n < TPOC_PINS; n++)
    begin : g_pin
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                port_b_pins[n] <= 1'b0;
            end
            else if (pin_function[2*n+1 -: 2] == TPOC_PIN_FN_PATTERN)
            begin
                port_b_pins[n] <= pattern[n];
            end
            else
            begin
                port_b_pins[n] <= general_out[n];
            end
        end
    end

endmodule // tpoc_pin_mux

/* logic/tpoc_ctrl.sv */
// Purpose: timing pattern output controller with axi4-lite registers
// Assumes: compare match inputs are one-cycle pulses on aclk
// Notes: one write and one read outstanding at most
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns

module tpoc_ctrl
    import tpoc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] cmp_match_a,
    input wire logic [3:0] cmp_match_b,
    input wire logic [15:0] general_out_data,
    output logic [15:0] pattern_output_pins,
    output logic [15:0] port_b_pins
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic tpoc_reg_e reg_decode(input logic [31:0] addr);
        tpoc_reg_e r;
        r = TPOC_REG_NONE;
        case (addr[31:2])
            TPOC_IDX_MODE: r = TPOC_REG_MODE;
            TPOC_IDX_TRIG: r = TPOC_REG_TRIG;
            TPOC_IDX_EN_HIGH: r = TPOC_REG_EN_HIGH;
            TPOC_IDX_EN_LOW: r = TPOC_REG_EN_LOW;
            TPOC_IDX_STAGE_B_UP: r = TPOC_REG_STAGE_B_UP;
            TPOC_IDX_STAGE_A_UP: r = TPOC_REG_STAGE_A_UP;
            TPOC_IDX_STAGE_B_LO: r = TPOC_REG_STAGE_B_LO;
            TPOC_IDX_STAGE_A_LO: r = TPOC_REG_STAGE_A_LO;
            TPOC_IDX_PIN_FN_HIGH: r = TPOC_REG_PIN_FN_HIGH;
            TPOC_IDX_PIN_FN_LOW: r = TPOC_REG_PIN_FN_LOW;
            default: r = TPOC_REG_NONE;
        endcase
        return r;
    endfunction

    // picks one channel's match pulse by a two-bit code
    function automatic logic chan_pick(input logic [1:0] code,
                                       input logic [3:0] pulses);
        return pulses[code];
    endfunction

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [3:0] split_mode_q;
    logic [7:0] trig_sel_q;
    logic [7:0] en_high_q;
    logic [7:0] en_low_q;
    logic [3:0] staged_q [TPOC_GROUPS];
    logic [15:0] pin_fn_high_q;
    logic [15:0] pin_fn_low_q;
    logic [15:0] enable_all;
    logic [15:0] pattern_all;
    logic same_trig_lo;
    logic same_trig_hi;

    // ****************************************************************
    // write channel
    // ****************************************************************
    logic aw_held_q;
    logic w_held_q;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic do_write;
    tpoc_reg_e wr_reg;
    logic wr_lane0;
    logic wr_lane1;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign wr_reg = reg_decode(aw_addr_q);
    assign wr_lane0 = do_write && w_strb_q[0];
    assign wr_lane1 = do_write && w_strb_q[1];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= TPOC_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_reg == TPOC_REG_NONE) ? TPOC_RESP_SLVERR
                                                 : TPOC_RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // control registers
    // ****************************************************************
    // reserved upper mode bits are not stored at all
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            split_mode_q <= TPOC_MODE_RESET;
        end
        else if (wr_lane0 && wr_reg == TPOC_REG_MODE)
        begin
            split_mode_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            trig_sel_q <= TPOC_TRIG_RESET;
        end
        else if (wr_lane0 && wr_reg == TPOC_REG_TRIG)
        begin
            trig_sel_q <= w_data_q[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_high_q <= TPOC_EN_RESET;
            en_low_q <= TPOC_EN_RESET;
        end
        else
        begin
            if (wr_lane0 && wr_reg == TPOC_REG_EN_HIGH)
            begin
                en_high_q <= w_data_q[7:0];
            end
            if (wr_lane0 && wr_reg == TPOC_REG_EN_LOW)
            begin
                en_low_q <= w_data_q[7:0];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_fn_high_q <= TPOC_PIN_FN_RESET;
            pin_fn_low_q <= TPOC_PIN_FN_RESET;
        end
        else
        begin
            if (wr_reg == TPOC_REG_PIN_FN_HIGH)
            begin
                if (wr_lane0)
                    pin_fn_high_q[7:0] <= w_data_q[7:0];
                if (wr_lane1)
                    pin_fn_high_q[15:8] <= w_data_q[15:8];
            end
            if (wr_reg == TPOC_REG_PIN_FN_LOW)
            begin
                if (wr_lane0)
                    pin_fn_low_q[7:0] <= w_data_q[7:0];
                if (wr_lane1)
                    pin_fn_low_q[15:8] <= w_data_q[15:8];
            end
        end
    end

    // ****************************************************************
    // staged pattern bits
    // ****************************************************************
    // a pair with one shared trigger is packed into the first byte;
    // with separate triggers the lower group moves to the second byte
    assign same_trig_lo = trig_sel_q[3:2] == trig_sel_q[1:0];
    assign same_trig_hi = trig_sel_q[7:6] == trig_sel_q[5:4];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int g = 0; g < TPOC_GROUPS; g++)
                staged_q[g] <= TPOC_STAGE_RESET;
        end
        else if (wr_lane0)
        begin
            case (wr_reg)
                TPOC_REG_STAGE_A_UP:
                begin
                    staged_q[1] <= w_data_q[7:4];
                    if (same_trig_lo)
                        staged_q[0] <= w_data_q[3:0];
                end
                TPOC_REG_STAGE_A_LO:
                begin
                    if (!same_trig_lo)
                        staged_q[0] <= w_data_q[3:0];
                end
                TPOC_REG_STAGE_B_UP:
                begin
                    staged_q[3] <= w_data_q[7:4];
                    if (same_trig_hi)
                        staged_q[2] <= w_data_q[3:0];
                end
                TPOC_REG_STAGE_B_LO:
                begin
                    if (!same_trig_hi)
                        staged_q[2] <= w_data_q[3:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] rd_byte;
    logic [15:0] rd_half;
    tpoc_reg_e rd_reg;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign rd_reg = reg_decode(s_axi_araddr);

    always_comb
    begin
        rd_byte = 8'h00;
        rd_half = 16'h0000;
        case (rd_reg)
            TPOC_REG_MODE: rd_byte = TPOC_MODE_RSVD | {4'h0, split_mode_q};
            TPOC_REG_TRIG: rd_byte = trig_sel_q;
            TPOC_REG_EN_HIGH: rd_byte = en_high_q;
            TPOC_REG_EN_LOW: rd_byte = en_low_q;
            TPOC_REG_STAGE_A_UP:
                rd_byte = {staged_q[1],
                           same_trig_lo ? staged_q[0] : TPOC_NIBBLE_RSVD};
            TPOC_REG_STAGE_A_LO:
                rd_byte = same_trig_lo ? TPOC_BYTE_RSVD
                                       : {TPOC_NIBBLE_RSVD, staged_q[0]};
            TPOC_REG_STAGE_B_UP:
                rd_byte = {staged_q[3],
                           same_trig_hi ? staged_q[2] : TPOC_NIBBLE_RSVD};
            TPOC_REG_STAGE_B_LO:
                rd_byte = same_trig_hi ? TPOC_BYTE_RSVD
                                       : {TPOC_NIBBLE_RSVD, staged_q[2]};
            TPOC_REG_PIN_FN_HIGH: rd_half = pin_fn_high_q;
            TPOC_REG_PIN_FN_LOW: rd_half = pin_fn_low_q;
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= TPOC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_half | {8'h00, rd_byte}};
            rresp_q <= (rd_reg == TPOC_REG_NONE) ? TPOC_RESP_SLVERR
                                                 : TPOC_RESP_OKAY;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // pattern groups
    // ****************************************************************
    assign enable_all = {en_high_q, en_low_q};

    for (genvar g = 0; g < TPOC_GROUPS; g++)
    begin : g_group
        logic trig_a;
        logic trig_b;
        // channel code sits at bits 2g+1..2g
        assign trig_a = chan_pick(trig_sel_q[2*g+1 -: 2], cmp_match_a);
        assign trig_b = chan_pick(trig_sel_q[2*g+1 -: 2], cmp_match_b);

        tpoc_group u_group (
            .aclk(aclk),
            .aresetn(aresetn),
            .trig_a(trig_a),
            .trig_b(trig_b),
            .split_edge_mode(split_mode_q[g]),
            .enable(enable_all[4*g+3 -: 4]),
            .staged(staged_q[g]),
            .pattern_q(pattern_all[4*g+3 -: 4])
        );
    end

    assign pattern_output_pins = pattern_all;

    tpoc_pin_mux u_pin_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_function({pin_fn_high_q, pin_fn_low_q}),
        .pattern(pattern_all),
        .general_out(general_out_data),
        .port_b_pins(port_b_pins)
    );

endmodule // tpoc_ctrl

/* verification/tpoc_ctrl_chk.sv */
// Purpose: port checker for tpoc_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top; sees ports only
`timescale 1ns/1ns
module tpoc_ctrl_chk
    import tpoc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] cmp_match_a,
    input wire logic [3:0] cmp_match_b,
    input wire logic [15:0] general_out_data,
    input wire logic [15:0] pattern_output_pins,
    input wire logic [15:0] port_b_pins
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic mapped;
    logic [29:0] ridx;
    assign ridx = s_axi_araddr[31:2];
    assign mapped = (ridx >= TPOC_IDX_MODE && ridx <= TPOC_IDX_STAGE_A_LO)
        || ridx == TPOC_IDX_PIN_FN_HIGH || ridx == TPOC_IDX_PIN_FN_LOW;
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_unmapped: assert property (rd_taken ##0 !mapped |=>
        s_axi_rresp == TPOC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_write_block: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_idle_pattern: assert property (
        cmp_match_a == 4'h0 && cmp_match_b == 4'h0 |=>
        $stable(pattern_output_pins))
        else $error("pattern moved without a match");
    a_reset_clear: assert property ($rose(aresetn) |->
        pattern_output_pins == 16'h0 && port_b_pins == 16'h0)
        else $error("outputs not cleared by reset");
    a_pin_follow: assert property (1'b1 |=> (
        (port_b_pins ^ $past(pattern_output_pins))
        & ~($past(pattern_output_pins) ^ $past(general_out_data)))
        == 16'h0)
        else $error("pin does not follow its sources");
endmodule // tpoc_ctrl_chk

/* verification/tpoc_pin_load.sv */
// Purpose: load standing on the port b pins
// Assumes: pins are sampled on aclk
// Notes: holds the last level it saw, as an outside latch would
`timescale 1ns/1ns
module tpoc_pin_load
(
    input wire logic aclk,
    input wire logic [15:0] port_b_pins,
    output logic [15:0] seen_q
);
    // ****************************************************************
    // sampling
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        seen_q <= port_b_pins;
    end
endmodule // tpoc_pin_load

/* verification/timing_pattern_output_ctrl_tb_top.sv */
// Purpose: self-checking bench for tpoc_ctrl
// Assumes: address and data offered together, one access at a time
// Notes: staged values alternate so each update is visible
`timescale 1ns/1ns
module timing_pattern_output_ctrl_tb_top
    import tpoc_pkg::*;
;
    // ****************************************************************
    // signals and tasks
    // ****************************************************************
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb, cmp_match_a, cmp_match_b;
    logic [15:0] general_out_data, pattern_output_pins, port_b_pins;
    logic [15:0] seen, exp_pat, v, en;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    tpoc_ctrl tpoc_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_match_a,
        .cmp_match_b, .general_out_data, .pattern_output_pins, .port_b_pins);
    tpoc_pin_load tpoc_pin_load_inst (.aclk, .port_b_pins, .seen_q(seen));
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ready is sampled at the falling edge: it cannot move before the rise
    task automatic wr(input logic [29:0] idx, input logic [31:0] d,
        input logic [1:0] er);
        logic a, w, b;
        logic [1:0] rs;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge aclk);
            a = s_axi_awready && s_axi_awvalid;
            w = s_axi_wready && s_axi_wvalid;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        chk("bresp", {30'h0, rs}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [29:0] idx, input logic [31:0] ex,
        input logic [1:0] er);
        logic a, r;
        logic [31:0] d;
        logic [1:0] rs;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        while (!r)
        begin
            @(negedge aclk);
            a = s_axi_arready && s_axi_arvalid;
            r = s_axi_rvalid;
            d = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'b0;
        end
        chk("rdata", d, ex);
        chk("rresp", {30'h0, rs}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pulse(input logic [3:0] a, input logic [3:0] b);
        cmp_match_a <= a;
        cmp_match_b <= b;
        @(posedge aclk);
        cmp_match_a <= 4'h0;
        cmp_match_b <= 4'h0;
        repeat (4) @(posedge aclk);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] t;
        logic [15:0] m;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        {aresetn, s_axi_rready, cmp_match_a, cmp_match_b} = 10'h0;
        s_axi_wstrb = 4'hf;
        general_out_data = 16'haaaa;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(TPOC_IDX_MODE, 32'hf0, TPOC_RESP_OKAY);
        rd(TPOC_IDX_TRIG, 32'hff, TPOC_RESP_OKAY);
        rd(TPOC_IDX_EN_HIGH, 32'h0, TPOC_RESP_OKAY);
        rd(TPOC_IDX_EN_LOW, 32'h0, TPOC_RESP_OKAY);
        rd(TPOC_IDX_STAGE_A_LO, 32'hff, TPOC_RESP_OKAY);
        wr(TPOC_IDX_MODE, 32'hff, TPOC_RESP_OKAY);
        rd(TPOC_IDX_MODE, 32'hff, TPOC_RESP_OKAY);
        wr(TPOC_IDX_MODE, 32'h00, TPOC_RESP_OKAY);
        wr(30'h05fffff8, 32'h5a, TPOC_RESP_SLVERR);
        rd(30'h05fffff8, 32'h0, TPOC_RESP_SLVERR);
        wr(TPOC_IDX_PIN_FN_LOW, 32'hc000, TPOC_RESP_OKAY);
        exp_pat = 16'h0;
        for (int r = 0; r < 4; r++)
        begin
            v = r[0] ? 16'ha5c3 : 16'h5a3c;
            en = r[0] ? 16'hffff : 16'hc33c;
            for (int g = 0; g < 4; g++)
                t[2 * g +: 2] = 2'((g + r) % 4);
            wr(TPOC_IDX_TRIG, {24'h0, t}, TPOC_RESP_OKAY);
            wr(TPOC_IDX_EN_HIGH, {24'h0, en[15:8]}, TPOC_RESP_OKAY);
            wr(TPOC_IDX_EN_LOW, {24'h0, en[7:0]}, TPOC_RESP_OKAY);
            rd(TPOC_IDX_EN_HIGH, {24'h0, en[15:8]}, TPOC_RESP_OKAY);
            wr(TPOC_IDX_STAGE_B_UP, {24'h0, v[15:12], 4'h0}, TPOC_RESP_OKAY);
            wr(TPOC_IDX_STAGE_B_LO, {28'h0, v[11:8]}, TPOC_RESP_OKAY);
            wr(TPOC_IDX_STAGE_A_UP, {24'h0, v[7:4], 4'h0}, TPOC_RESP_OKAY);
            wr(TPOC_IDX_STAGE_A_LO, {28'h0, v[3:0]}, TPOC_RESP_OKAY);
            pulse(4'h0, 4'hf);
            chk("match b", {16'h0, pattern_output_pins}, {16'h0, exp_pat});
            for (int c = 0; c < 4; c++)
            begin
                pulse(4'h1 << c, 4'h0);
                m = (16'hf << (4 * ((c + 4 - r) % 4))) & en;
                exp_pat = (exp_pat & ~m) | (v & m);
                chk("pattern", {16'h0, pattern_output_pins}, {16'h0, exp_pat});
                chk("pins", {16'h0, seen}, {16'h0, 16'haa2a | (exp_pat & 16'h0080)});
            end
        end
        // group 0 split on channel 3: match b clears, match a sets
        wr(TPOC_IDX_MODE, 32'h01, TPOC_RESP_OKAY);
        rd(TPOC_IDX_MODE, 32'hf1, TPOC_RESP_OKAY);
        wr(TPOC_IDX_STAGE_A_LO, 32'h06, TPOC_RESP_OKAY);
        pulse(4'h0, 4'h8);
        exp_pat[3:0] = exp_pat[3:0] & 4'h6;
        chk("split b", {16'h0, pattern_output_pins}, {16'h0, exp_pat});
        pulse(4'h8, 4'h0);
        exp_pat[3:0] = exp_pat[3:0] | 4'h6;
        chk("split a", {16'h0, pattern_output_pins}, {16'h0, exp_pat});
        stop_test();
    end
endmodule // timing_pattern_output_ctrl_tb_top
bind tpoc_ctrl tpoc_ctrl_chk tpoc_ctrl_chk_inst (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_match_a, .cmp_match_b,
    .general_out_data, .pattern_output_pins, .port_b_pins);
